// >>> ofs_consts.svh
// Contract
// - supply current channel triggers on peak OR average current flag
// - three identical channels: overdrive, underdrive, supply overload
// - fault rising edge starts a one second first pulse, high and low
// - first pulses of all channels ORed into the type 2 fault output
// - first pulse end starts a 2.4 second second pulse
// - repeat signal high only when first and second pulses overlap
// - each repeat signal ORed into the type 1 fault request
// - repeat signal sets that channel's fault status latch
// - no fault before second pulse ends returns channel to idle
// - lamp green idle, amber first pulse, off window, red on repeat
// - average current flag forwarded to the audio input stage
// - first pulse removes supply one second, its end arms repeats
// - red overload indication holds until manual status reset
`ifndef OFS_CONSTS_SVH
`define OFS_CONSTS_SVH

`define OFS_NUM_CH      3
`define OFS_CH_OVER     0
`define OFS_CH_UNDER    1
`define OFS_CH_CURR     2
`define OFS_CLK_MHZ     125
`define OFS_T1_MS       1000
`define OFS_T2_MS       2400
`define OFS_T1_CYCLES   (`OFS_T1_MS * 1000 * `OFS_CLK_MHZ)
`define OFS_T2_CYCLES   (`OFS_T2_MS * 1000 * `OFS_CLK_MHZ)
`define OFS_CNT_W       32
`define OFS_SYNC_RST    1'b0

`endif

// >>> ofs_pkg.sv
package ofs_pkg;

   // comparator flags as they arrive from the pins
   typedef struct packed {
      logic avg_cur;
      logic peak_cur;
      logic rf_under;
      logic rf_over;
   } ofs_flags_s;

   // colour sections of one bicolor lamp
   typedef struct packed {
      logic red;
      logic green;
   } ofs_lamp_s;

   typedef enum logic [1:0] {
      OFS_GREEN = 2'b00,
      OFS_AMBER = 2'b01,
      OFS_DARK  = 2'b10,
      OFS_RED   = 2'b11
   } ofs_lamp_e;

endpackage

// >>> ofs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ofs_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // ****************************************************************
   // three stages, output follows once stages two and three agree
   // ****************************************************************
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= async_i;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   genvar b;
   generate
      for (b = 0; b < WIDTH; b++) begin : gen_bit
         always_ff @(posedge clock_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               sync_o[b] <= 1'b0;
            end else if (stage2[b] == stage3[b]) begin
               sync_o[b] <= stage3[b];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// >>> ofs_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.svh"
module ofs_top
   import ofs_pkg::*;
#(
   parameter int unsigned NUM_CH    = `OFS_NUM_CH,
   parameter int unsigned CNT_W     = `OFS_CNT_W,
   parameter int unsigned T1_CYCLES = `OFS_T1_CYCLES,
   parameter int unsigned T2_CYCLES = `OFS_T2_CYCLES
) (
   input  wire logic              clock_i,
   input  wire logic              sys_rst_i,
   input  wire logic              rf_over_i,
   input  wire logic              rf_under_i,
   input  wire logic              peak_cur_i,
   input  wire logic              avg_cur_i,
   input  wire logic              status_reset_i,
   output logic                   type2_fault_o,
   output logic                   type1_fault_o,
   output logic                   avg_cur_fwd_o,
   output logic      [NUM_CH-1:0] lamp_red_o,
   output logic      [NUM_CH-1:0] lamp_green_o,
   output logic      [NUM_CH-1:0] fault_latch_o
);

   // ****************************************************************
   // pin synchronisation
   // ****************************************************************
   ofs_flags_s       flags_raw;
   ofs_flags_s       flags;
   logic             status_clr;

   assign flags_raw.rf_over  = rf_over_i;
   assign flags_raw.rf_under = rf_under_i;
   assign flags_raw.peak_cur = peak_cur_i;
   assign flags_raw.avg_cur  = avg_cur_i;

   ofs_sync #(
      .WIDTH     ($bits(ofs_flags_s))
   ) u_sync_flags (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (flags_raw),
      .sync_o    (flags)
   );

   ofs_sync #(
      .WIDTH     (1)
   ) u_sync_clr (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (status_reset_i),
      .sync_o    (status_clr)
   );

   // ****************************************************************
   // channel inputs
   // ****************************************************************
   wire logic [NUM_CH-1:0] chan_fault;
   wire logic              curr_fault;

   assign curr_fault = flags.peak_cur | flags.avg_cur;
   assign chan_fault[`OFS_CH_OVER]  = flags.rf_over;
   assign chan_fault[`OFS_CH_UNDER] = flags.rf_under;
   assign chan_fault[`OFS_CH_CURR]  = curr_fault;

   localparam logic [CNT_W-1:0] T1_LOAD = CNT_W'(T1_CYCLES);
   localparam logic [CNT_W-1:0] T2_LOAD = CNT_W'(T2_CYCLES);
   localparam logic [CNT_W-1:0] ONE     = CNT_W'(1);

   logic [NUM_CH-1:0] first_act;
   logic [NUM_CH-1:0] repeat_now;
   logic [NUM_CH-1:0] next_red;
   logic [NUM_CH-1:0] next_green;
   logic [NUM_CH-1:0] latch_q;

   // ****************************************************************
   // per channel timers, repeat detector, latch and lamp
   // ****************************************************************
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : gen_ch
         logic             fault_d;
         logic [CNT_W-1:0] t1_cnt;
         logic [CNT_W-1:0] t2_cnt;
         logic             latch;
         logic [CNT_W-1:0] next_t1;
         logic [CNT_W-1:0] next_t2;
         logic             next_latch;
         wire logic        trig;
         wire logic        t1_act;
         wire logic        t2_act;
         wire logic        t1_end;
         ofs_lamp_e        lamp_state;
         ofs_lamp_s        lamp;

         // rising edge of the synchronised flag
         assign trig   = chan_fault[ch] & ~fault_d;
         assign t1_act = (t1_cnt != '0);
         assign t2_act = (t2_cnt != '0);
         // first pulse ends without being restarted
         assign t1_end = (t1_cnt == ONE) & ~trig;

         // restart on every new edge
         assign next_t1 = trig   ? T1_LOAD :
                          t1_act ? t1_cnt - ONE : '0;
         assign next_t2 = t1_end ? T2_LOAD :
                          t2_act ? t2_cnt - ONE : '0;

         // window running out alone leaves nothing behind
         assign repeat_now[ch] = t1_act & t2_act;
         // set wins over a clear in the same cycle
         assign next_latch = repeat_now[ch] |
                             (latch & ~status_clr);

         assign first_act[ch] = t1_act;
         assign latch_q[ch]   = latch;

         always_ff @(posedge clock_i or posedge sys_rst_i) begin
            if (sys_rst_i) begin
               fault_d <= 1'b0;
               t1_cnt  <= '0;
               t2_cnt  <= '0;
               latch   <= 1'b0;
            end else if (status_clr) begin
               fault_d <= chan_fault[ch];
               t1_cnt  <= '0;
               t2_cnt  <= '0;
               latch   <= next_latch;
            end else begin
               fault_d <= chan_fault[ch];
               t1_cnt  <= next_t1;
               t2_cnt  <= next_t2;
               latch   <= next_latch;
            end
         end

         // lamp priority: red on latch or repeat, then first pulse, then window
         always_comb begin
            if (latch | repeat_now[ch]) begin
               lamp_state = OFS_RED;
            end else if (t1_act) begin
               lamp_state = OFS_AMBER;
            end else if (t2_act) begin
               lamp_state = OFS_DARK;
            end else begin
               lamp_state = OFS_GREEN;
            end
         end

         always_comb begin
            case (lamp_state)
               OFS_GREEN: begin
                  lamp = '{red: 1'b0, green: 1'b1};
               end
               OFS_AMBER: begin
                  lamp = '{red: 1'b1, green: 1'b1};
               end
               OFS_DARK: begin
                  lamp = '{red: 1'b0, green: 1'b0};
               end
               OFS_RED: begin
                  lamp = '{red: 1'b1, green: 1'b0};
               end
               default: begin
                  lamp = '{red: 1'b0, green: 1'b1};
               end
            endcase
         end

         assign next_red[ch]   = lamp.red;
         assign next_green[ch] = lamp.green;
      end
   endgenerate

   // ****************************************************************
   // combined fault requests
   // ****************************************************************
   wire logic next_type2;
   wire logic next_type1;

   // supply off for the length of any first pulse
   assign next_type2 = |first_act;
   assign next_type1 = |repeat_now;

   // ****************************************************************
   // output registers
   // ****************************************************************
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         type2_fault_o <= 1'b0;
         type1_fault_o <= 1'b0;
         avg_cur_fwd_o <= 1'b0;
         lamp_red_o    <= '0;
         lamp_green_o  <= '1;
         fault_latch_o <= '0;
      end else begin
         type2_fault_o <= next_type2;
         type1_fault_o <= next_type1;
         avg_cur_fwd_o <= flags.avg_cur;
         lamp_red_o    <= next_red;
         lamp_green_o  <= next_green;
         fault_latch_o <= latch_q;
      end
   end

endmodule
`default_nettype wire

// >>> ofs_props.sv
`timescale 1ns/1ps
`default_nettype none
module ofs_props
   import ofs_pkg::*;
#(
   parameter int unsigned NUM_CH    = 3,
   parameter int unsigned CNT_W     = 32,
   parameter int unsigned T1_CYCLES = 20,
   parameter int unsigned T2_CYCLES = 48
) (
   input wire logic              clock_i,
   input wire logic              sys_rst_i,
   input wire logic              rf_over_i,
   input wire logic              rf_under_i,
   input wire logic              peak_cur_i,
   input wire logic              avg_cur_i,
   input wire logic              status_reset_i,
   input wire logic              type2_fault_o,
   input wire logic              type1_fault_o,
   input wire logic              avg_cur_fwd_o,
   input wire logic [NUM_CH-1:0] lamp_red_o,
   input wire logic [NUM_CH-1:0] lamp_green_o,
   input wire logic [NUM_CH-1:0] fault_latch_o
);
   // ********************
   // pulse length and clear age
   // ********************
   logic [31:0] hi_len;
   logic [7:0]  clr_age;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hi_len  <= '0;
         clr_age <= '0;
      end else begin
         hi_len  <= type2_fault_o ? hi_len + 32'h0000_0001 : '0;
         clr_age <= status_reset_i ? '0 : clr_age + {7'h0, clr_age != 8'hff};
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   fwd_follow_a: assert property (
      $rose(avg_cur_i) |-> ##[2:8] avg_cur_fwd_o)
      else $error("avg forward missing");
   // a repeat or a held latch shows red, not amber
   amber_rise_a: assert property (
      $rose(type2_fault_o) && !type1_fault_o && fault_latch_o == '0
      |-> ##[0:1] |(lamp_red_o & lamp_green_o))
      else $error("no amber on pulse");
   repeat_t2_a: assert property (
      type1_fault_o |-> type2_fault_o)
      else $error("type1 without first pulse");
   repeat_latch_a: assert property (
      $rose(type1_fault_o) |-> ##[0:2] (fault_latch_o != '0))
      else $error("latch not set");
   latch_hold_a: assert property (
      (|($past(fault_latch_o) & ~fault_latch_o)) |-> clr_age < 8'h0a)
      else $error("latch lost");
   red_latch_a: assert property (
      ((fault_latch_o & $past(fault_latch_o)) & ~lamp_red_o) == '0)
      else $error("latched lamp not red");
   pulse_len_a: assert property (
      $fell(type2_fault_o) && clr_age == 8'hff |-> hi_len >= T1_CYCLES)
      else $error("first pulse short");
   idle_quiet_a: assert property (
      (&lamp_green_o) && lamp_red_o == '0
      |-> !type1_fault_o && !type2_fault_o)
      else $error("idle lamp in fault");
   cover property ($rose(type1_fault_o));
   cover property ($fell(|fault_latch_o));
   cover property ($rose(avg_cur_fwd_o));
endmodule
bind ofs_top ofs_props #(.NUM_CH(NUM_CH), .CNT_W(CNT_W),
   .T1_CYCLES(T1_CYCLES), .T2_CYCLES(T2_CYCLES)) ofs_props_inst (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rf_over_i(rf_over_i),
   .rf_under_i(rf_under_i), .peak_cur_i(peak_cur_i), .avg_cur_i(avg_cur_i),
   .status_reset_i(status_reset_i), .type2_fault_o(type2_fault_o),
   .type1_fault_o(type1_fault_o), .avg_cur_fwd_o(avg_cur_fwd_o),
   .lamp_red_o(lamp_red_o), .lamp_green_o(lamp_green_o),
   .fault_latch_o(fault_latch_o));
`default_nettype wire

// >>> ofs_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ofs_partner
   import ofs_pkg::*;
#(
   parameter int unsigned HOLD = 6
) (
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   input  wire logic [3:0] fire_i,
   input  wire logic       type2_i,
   input  wire logic       type1_i,
   output var ofs_flags_s  flags_o,
   output logic            pa_on_o,
   output logic            tx_on_o
);
   // ********************
   // comparators and controller
   // ********************
   logic [3:0] mask;
   logic [7:0] cnt;
   // peak and average flags stay separate comparators
   assign flags_o = (cnt != 8'h0) ? mask : 4'h0;
   // supply off while the first pulse runs
   assign pa_on_o = !type2_i;
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mask    <= 4'h0;
         cnt     <= 8'h0;
         tx_on_o <= 1'b1;
      end else begin
         mask    <= (fire_i != 4'h0) ? fire_i : mask;
         cnt     <= (fire_i != 4'h0) ? 8'(HOLD) : cnt - {7'h0, cnt != 8'h0};
         tx_on_o <= tx_on_o & !type1_i;
      end
   end
endmodule
`default_nettype wire

// >>> ofs_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ofs_top_bench
   import ofs_pkg::*;
;
   localparam int T1 = 20;
   localparam int T2 = 48;
   typedef struct {logic [3:0] fire; logic [2:0] ch;} ofs_row_s;
   ofs_row_s   rows [4] = '{'{4'h1, 3'h1}, '{4'h2, 3'h2}, '{4'h4, 3'h4},
                            '{4'h8, 3'h4}};
   logic       clock_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic       status_reset_i = 1'b0;
   logic [3:0] fire = 4'h0;
   ofs_flags_s flags;
   logic       type2, type1, fwd, pa_on, tx_on;
   logic [2:0] red, green, latch;
   int         errors = 0;
   int         compares = 0;
   int         n;
   ofs_top #(.T1_CYCLES(T1), .T2_CYCLES(T2)) ofs_top_inst (
      .clock_i(clock_i), .sys_rst_i(sys_rst_i), .rf_over_i(flags.rf_over),
      .rf_under_i(flags.rf_under), .peak_cur_i(flags.peak_cur),
      .avg_cur_i(flags.avg_cur), .status_reset_i(status_reset_i),
      .type2_fault_o(type2), .type1_fault_o(type1), .avg_cur_fwd_o(fwd),
      .lamp_red_o(red), .lamp_green_o(green), .fault_latch_o(latch));
   ofs_partner ofs_partner_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .fire_i(fire), .type2_i(type2), .type1_i(type1), .flags_o(flags),
      .pa_on_o(pa_on), .tx_on_o(tx_on));
   // ********************
   // helpers
   // ********************
   task automatic final_report();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock_i);
      #1;
   endtask
   task automatic lamps(input logic [2:0] r, input logic [2:0] g);
      check({26'h0, red, green}, {26'h0, r, g});
   endtask
   task automatic fire_it(input logic [3:0] m);
      fire = m;
      tick(1);
      fire = 4'h0;
   endtask
   task automatic wait_sig(input int sel, input logic lvl);
      n = 0;
      while ((sel ? type1 : type2) !== lvl && n < 400) begin
         tick(1);
         n++;
      end
      if (n >= 400) begin
         errors++;
         final_report();
      end
   endtask
   initial forever #4 clock_i = ~clock_i;
   initial begin
      tick(4);
      lamps(3'h0, 3'h7);
      sys_rst_i = 1'b0;
      foreach (rows[i]) begin
         fire_it(rows[i].fire);
         wait_sig(0, 1'b1);
         lamps(rows[i].ch, 3'h7);
         check({31'h0, fwd}, {31'h0, rows[i].fire[3]});
         check({31'h0, pa_on}, 32'h0);
         wait_sig(0, 1'b0);
         check(32'(n), 32'(T1));
         tick(2);
         lamps(3'h0, ~rows[i].ch);
         tick(T2);
         lamps(3'h0, 3'h7);
         check({28'h0, latch, type1}, 32'h0);
      end
      for (int k = 0; k < 3; k++) begin
         fire_it(rows[k].fire);
         wait_sig(0, 1'b1);
         wait_sig(0, 1'b0);
         tick(T2 / 2);
         fire_it(rows[k].fire);
         wait_sig(1, 1'b1);
         tick(2);
         check({29'h0, latch}, {29'h0, rows[k].ch});
         lamps(rows[k].ch, ~rows[k].ch);
         check({31'h0, tx_on}, 32'h0);
         check({31'h0, type1}, 32'h1);
         tick(T1 + T2 + 10);
         check({29'h0, latch}, {29'h0, rows[k].ch});
         lamps(rows[k].ch, ~rows[k].ch);
         status_reset_i = 1'b1;
         tick(3);
         status_reset_i = 1'b0;
         tick(8);
         check({29'h0, latch}, 32'h0);
         lamps(3'h0, 3'h7);
      end
      fire_it(4'h2);
      wait_sig(0, 1'b1);
      tick(8);
      fire_it(4'h2);
      tick(T1 - 7);
      check({31'h0, type2}, 32'h1);
      wait_sig(0, 1'b0);
      tick(T2 + 10);
      check({28'h0, latch, type1}, 32'h0);
      fire_it(4'h1);
      wait_sig(0, 1'b1);
      sys_rst_i = 1'b1;
      tick(2);
      lamps(3'h0, 3'h7);
      check({27'h0, latch, type2, type1}, 32'h0);
      sys_rst_i = 1'b0;
      tick(T1 + 10);
      lamps(3'h0, 3'h7);
      check({27'h0, latch, type2, type1}, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
